// ==== hw/cst_regs.svh ====
// constants for the charge safety timer and temperature zone block
// assumes a 20 MHz pclk and 32-bit apb word registers
`ifndef CST_REGS_SVH
`define CST_REGS_SVH

// ==========================================================
// register offsets (byte addresses)
`define CST_OFF_CTRL       12'h000
`define CST_OFF_STATUS     12'h004
`define CST_OFF_FLAG       12'h008

// ==========================================================
// ctrl field positions
`define CST_B_CHG_EN       0
`define CST_B_TRK_EN       1
`define CST_B_PRE_EN       2
`define CST_B_FAST_EN      3
`define CST_B_HALF_EN      4
`define CST_B_PRE_SEL      5
`define CST_B_FAST_SEL     6
`define CST_B_BYPASS       8
`define CST_B_TMASK        9
`define CST_B_COOL_CUR     10
`define CST_B_WARM_VOLT    12
`define CST_B_COOL_THR     16
`define CST_B_WARM_THR     18
`define CST_CTRL_MASK      32'h000f_7fff
`define CST_CTRL_RST       32'h0000_0c9f

// ==========================================================
// flag bits: timer expiry per stage, zone change
`define CST_F_TRK          0
`define CST_F_PRE          1
`define CST_F_FAST         2
`define CST_F_ZONE         3

// ==========================================================
// timing, durations in seconds
`define CST_CLK_HZ         20000000
`define CST_TICK_S         1
`define CST_TICK_CYCLES    (`CST_TICK_S * `CST_CLK_HZ)
`define CST_EVENT_US       256
`define CST_EVENT_CYCLES   ((`CST_EVENT_US * (`CST_CLK_HZ / 1000)) / 1000)
`define CST_TRK_S          17'd3600
`define CST_PRE_LONG_S     17'd7200
`define CST_PRE_SHORT_S    17'd1800
`define CST_FAST_S0        17'd18000
`define CST_FAST_S1        17'd28800
`define CST_FAST_S2        17'd43200
`define CST_FAST_S3        17'd72000

`endif

// ==== hw/cst_pkg.sv ====
// types for the charge safety timer and temperature zone block
// assumes nothing beyond the constants header
package cst_pkg;

  // ==========================================================
  // charge stage, gray along idle-trickle-pre-fast
  typedef enum logic [1:0] {
    CST_IDLE    = 2'h0,
    CST_TRICKLE = 2'h1,
    CST_PRE     = 2'h3,
    CST_FAST    = 2'h2
  } cst_stage_t;

  // ==========================================================
  // temperature zone
  typedef enum logic [2:0] {
    CST_Z_NORMAL = 3'h0,
    CST_Z_COOL   = 3'h1,
    CST_Z_COLD   = 3'h3,
    CST_Z_WARM   = 3'h4,
    CST_Z_HOT    = 3'h6
  } cst_zone_t;

  // ==========================================================
  // analog regulation loop levels
  typedef struct packed {
    logic input_voltage_regulation;
    logic input_current_regulation;
    logic thermal_regulation;
  } cst_reg_loops_t;

  // termination sense levels
  typedef struct packed {
    logic term_enable;
    logic ibat_below_term;
    logic vbat_above_rechg;
    logic cv_loop_active;
  } cst_term_sense_t;

endpackage

// ==== hw/cst_timer.sv ====
// charge safety timers and temperature zone qualification, apb slave
// assumes synchronous comparator levels from the analog side, pclk 20 MHz
// Operation
// - fast timer expiry sets fast_timer_expired_fault and pulses event
// - trickle timer lasts a fixed one hour
// - precharge timer two hours by default, half hour when select set
// - fast timer duration chosen by a field, twelve hours by default
// - each timer stops when its own enable is zero
// - enabling a timer works in any state and restarts it from zero
// - a stage starting starts its own timer counting
// - regulation with half rate enabled halves the counting rate
// - dropping half rate enable waits until regulation ends
// - faults or supplement mode freeze the count and half rate state
// - trickle and precharge timers share suspend, reset, half rate
// - fast timer resets on restart, pre/fast change, duration change
// - precharge timer resets on restart, any neighbour change, select change
// - trickle timer resets on restart and trickle/pre change
// - charging runs only between the cold and hot limits
// - cool zone current is 20, 40, 100 percent or suspend
// - warm zone voltage is an offset code or suspend
// - termination unchanged across cool and warm zones
// - zones: suspend stops timer, 20/40 percent halves rate
// - bypass treats temperature as good and reports zero zone bits
// - zone change updates status, sets flag, pulses event unless masked
// - outer limits fixed, cool and warm boundaries selectable
// - events are active low 256 us pulses
// - trickle versus precharge decided by 2.2 V comparator
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps
`include "cst_regs.svh"

module cst_timer #(
  parameter int TICK_CYCLES  = `CST_TICK_CYCLES,
  parameter int EVENT_CYCLES = `CST_EVENT_CYCLES
) (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // charger side levels
  input  wire logic                  ce_n,
  input  wire logic                  recharge_start,
  input  wire logic                  vbat_below_short,
  input  wire logic                  vbat_below_lowv,
  input  wire logic                  charge_fault,
  input  wire logic                  supplement_mode,
  input  wire cst_pkg::cst_reg_loops_t  loops,
  input  wire cst_pkg::cst_term_sense_t term_sense,
  // temperature comparators: cold, cool, warm, hot
  input  wire logic [3:0]            temp_sense_input,
  // outputs to analog and host
  output logic [1:0]                 lower_mid_threshold_sel,
  output logic [1:0]                 upper_mid_threshold_sel,
  output logic                       charge_allowed,
  output logic [1:0]                 current_scale,
  output logic [2:0]                 voltage_offset,
  output logic                       termination,
  output cst_pkg::cst_stage_t        stage,
  output logic                       event_n
);

  // ==========================================================
  // registers and state
  logic [31:0]         ctrl_r;
  logic [3:0]          flag_r;
  logic [3:0]          ts_meta_r;
  logic [3:0]          ts_sync_r;
  cst_pkg::cst_zone_t  zone_r;
  cst_pkg::cst_zone_t  zone_nxt;
  cst_pkg::cst_stage_t stage_r;
  cst_pkg::cst_stage_t stage_nxt;
  logic [16:0]         cnt_r [3];
  logic [2:0]          fault_r;
  logic [2:0]          en_q_r;
  logic [2:0]          dur_q_r;
  logic                chg_on_q_r;
  logic                reg_half_r;
  logic                phase_r;
  logic [31:0]         pre_r;
  logic                tick;
  logic [31:0]         evt_cnt_r;

  // ==========================================================
  // control decode
  logic        chg_on;
  logic [2:0]  tmr_en;
  logic        half_en;
  logic        pre_sel;
  logic [1:0]  fast_sel;
  logic        bypass;
  logic        tmask;
  logic [1:0]  cool_cur;
  logic [2:0]  warm_volt;

  assign chg_on    = ctrl_r[`CST_B_CHG_EN] & ~ce_n;
  assign tmr_en    = ctrl_r[`CST_B_FAST_EN:`CST_B_TRK_EN];
  assign half_en   = ctrl_r[`CST_B_HALF_EN];
  assign pre_sel   = ctrl_r[`CST_B_PRE_SEL];
  assign fast_sel  = ctrl_r[`CST_B_FAST_SEL +: 2];
  assign bypass    = ctrl_r[`CST_B_BYPASS];
  assign tmask     = ctrl_r[`CST_B_TMASK];
  assign cool_cur  = ctrl_r[`CST_B_COOL_CUR +: 2];
  assign warm_volt = ctrl_r[`CST_B_WARM_VOLT +: 3];

  // duration of timer idx in seconds
  function automatic logic [16:0] limit_of(input int idx, input logic ps, input logic [1:0] fs);
    logic [16:0] v;
    v = `CST_TRK_S;
    if (idx == 1)
      v = ps ? `CST_PRE_SHORT_S : `CST_PRE_LONG_S;
    else if (idx == 2)
      case (fs)
        2'h0:    v = `CST_FAST_S0;
        2'h1:    v = `CST_FAST_S1;
        2'h2:    v = `CST_FAST_S2;
        default: v = `CST_FAST_S3;
      endcase
    return v;
  endfunction

  // ==========================================================
  // apb slave, one wait-free access phase
  logic wr_go;
  logic mapped;
  assign wr_go  = psel & penable & pready & pwrite;
  assign mapped = (paddr == `CST_OFF_CTRL) | (paddr == `CST_OFF_STATUS)
                | (paddr == `CST_OFF_FLAG);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite)
        case (paddr)
          `CST_OFF_CTRL:   prdata <= ctrl_r;
          `CST_OFF_STATUS: prdata <= {16'h0000, 1'b0, fault_r, 1'b0, reg_half_r | phase_r,
                                      stage_r, 1'b0, bypass ? 3'h0 : zone_r, 2'b00, termination,
                                      charge_allowed};
          `CST_OFF_FLAG:   prdata <= {28'h000_0000, flag_r};
          default:         prdata <= 32'h0000_0000;
        endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_r <= `CST_CTRL_RST;
    else if (wr_go && paddr == `CST_OFF_CTRL)
      ctrl_r <= pwdata & `CST_CTRL_MASK;
  end

  // ==========================================================
  // temperature zone
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ts_meta_r <= 4'h0;
      ts_sync_r <= 4'h0;
    end
    else
    begin
      ts_meta_r <= temp_sense_input;
      ts_sync_r <= ts_meta_r;
    end
  end

  always_comb
  begin
    if (ts_sync_r[0])
      zone_nxt = cst_pkg::CST_Z_COLD;
    else if (ts_sync_r[3])
      zone_nxt = cst_pkg::CST_Z_HOT;
    else if (ts_sync_r[1])
      zone_nxt = cst_pkg::CST_Z_COOL;
    else if (ts_sync_r[2])
      zone_nxt = cst_pkg::CST_Z_WARM;
    else
      zone_nxt = cst_pkg::CST_Z_NORMAL;
  end

  logic zone_chg;
  assign zone_chg = ~bypass & (zone_nxt != zone_r);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      zone_r <= cst_pkg::CST_Z_NORMAL;
    else
      zone_r <= bypass ? cst_pkg::CST_Z_NORMAL : zone_nxt;
  end

  // bypass reads as normal zone so everything is allowed
  logic zone_susp;
  logic zone_scaled;
  always_comb
  begin
    zone_susp   = 1'b0;
    zone_scaled = 1'b0;
    case (zone_r)
      cst_pkg::CST_Z_COLD,
      cst_pkg::CST_Z_HOT:  zone_susp = 1'b1;
      cst_pkg::CST_Z_COOL:
      begin
        zone_susp   = (cool_cur == 2'h0);
        zone_scaled = (cool_cur == 2'h1) | (cool_cur == 2'h2);
      end
      cst_pkg::CST_Z_WARM: zone_susp = (warm_volt == 3'h0);
      default:             zone_susp = 1'b0;
    endcase
  end

  // ==========================================================
  // charge stage from battery comparators
  always_comb
  begin
    if (!chg_on)
      stage_nxt = cst_pkg::CST_IDLE;
    else if (vbat_below_short)
      stage_nxt = cst_pkg::CST_TRICKLE;
    else if (vbat_below_lowv)
      stage_nxt = cst_pkg::CST_PRE;
    else
      stage_nxt = cst_pkg::CST_FAST;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stage_r <= cst_pkg::CST_IDLE;
    else
      stage_r <= stage_nxt;
  end

  // ==========================================================
  // reset events for the timers
  logic       restart;
  logic       tp_chg;
  logic       pf_chg;
  logic [2:0] dur_now;
  logic [2:0] tmr_rst;
  assign restart = (chg_on & ~chg_on_q_r) | recharge_start;
  assign tp_chg  = (stage_r == cst_pkg::CST_TRICKLE && stage_nxt == cst_pkg::CST_PRE)
                 | (stage_r == cst_pkg::CST_PRE && stage_nxt == cst_pkg::CST_TRICKLE);
  assign pf_chg  = (stage_r == cst_pkg::CST_PRE && stage_nxt == cst_pkg::CST_FAST)
                 | (stage_r == cst_pkg::CST_FAST && stage_nxt == cst_pkg::CST_PRE);
  assign dur_now = {fast_sel, pre_sel};
  assign tmr_rst[0] = restart | (tmr_en[0] & ~en_q_r[0]) | tp_chg;
  assign tmr_rst[1] = restart | (tmr_en[1] & ~en_q_r[1]) | tp_chg | pf_chg
                    | (dur_q_r[0] != dur_now[0]);
  assign tmr_rst[2] = restart | (tmr_en[2] & ~en_q_r[2]) | pf_chg
                    | (dur_q_r[2:1] != dur_now[2:1]);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_q_r     <= 3'h0;
      dur_q_r    <= 3'h0;
      chg_on_q_r <= 1'b0;
    end
    else
    begin
      en_q_r     <= tmr_en;
      dur_q_r    <= dur_now;
      chg_on_q_r <= chg_on;
    end
  end

  // ==========================================================
  // time base and half rate
  logic susp;
  logic reg_any;
  logic half;
  logic acc_tick;
  assign susp     = charge_fault | supplement_mode | zone_susp;
  assign reg_any  = |loops;
  assign half     = reg_half_r | zone_scaled;
  assign acc_tick = tick & ~susp & (~half | phase_r);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pre_r <= 32'h0000_0000;
    else if (pre_r >= 32'(TICK_CYCLES - 1))
      pre_r <= 32'h0000_0000;
    else
      pre_r <= pre_r + 32'h0000_0001;
  end
  assign tick = (pre_r >= 32'(TICK_CYCLES - 1));

  // half rate latches until regulation ends, frozen while suspended
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      reg_half_r <= 1'b0;
    else if (!susp)
      reg_half_r <= reg_any & (half_en | reg_half_r);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      phase_r <= 1'b0;
    else if (!half)
      phase_r <= 1'b0;
    else if (tick && !susp)
      phase_r <= ~phase_r;
  end

  // ==========================================================
  // the three stage timers: 0 trickle, 1 pre, 2 fast
  logic [2:0] run;
  logic [2:0] expire;
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      run[i]    = tmr_en[i] & ~(|fault_r)
                & (stage_r == (i == 0 ? cst_pkg::CST_TRICKLE :
                               i == 1 ? cst_pkg::CST_PRE : cst_pkg::CST_FAST));
      expire[i] = run[i] & acc_tick & ~tmr_rst[i]
                & (cnt_r[i] == limit_of(i, pre_sel, fast_sel) - 17'd1);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 3; i++)
        cnt_r[i] <= 17'h0_0000;
    end
    else
    begin
      for (int i = 0; i < 3; i++)
        if (tmr_rst[i])
          cnt_r[i] <= 17'h0_0000;
        else if (run[i] && acc_tick)
          cnt_r[i] <= cnt_r[i] + 17'h0_0001;
    end
  end

  // expiry faults hold until a new cycle; restart wins, masking a same-cycle expiry
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fault_r <= 3'h0;
    else
      fault_r <= expire | (fault_r & ~{3{restart}});
  end

  // ==========================================================
  // flags, write one to clear, set wins
  logic       flag_clr;
  logic [3:0] flag_set;
  assign flag_clr = wr_go & (paddr == `CST_OFF_FLAG);
  assign flag_set = {zone_chg, expire};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flag_r <= 4'h0;
    else
      flag_r <= flag_set | (flag_r & ~(flag_clr ? pwdata[3:0] : 4'h0));
  end

  // ==========================================================
  // host event pulse, retriggers on a fresh event
  logic evt_req;
  assign evt_req = (|expire) | (zone_chg & ~tmask);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      evt_cnt_r <= 32'h0000_0000;
      event_n   <= 1'b1;
    end
    else if (evt_req)
    begin
      evt_cnt_r <= 32'(EVENT_CYCLES - 1);
      event_n   <= 1'b0;
    end
    else if (evt_cnt_r != 32'h0000_0000)
      evt_cnt_r <= evt_cnt_r - 32'h0000_0001;
    else
      event_n   <= 1'b1;
  end

  // ==========================================================
  // outputs to the analog side
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lower_mid_threshold_sel <= 2'h0;
      upper_mid_threshold_sel <= 2'h0;
      charge_allowed          <= 1'b0;
      current_scale           <= 2'h3;
      voltage_offset          <= 3'h0;
      termination             <= 1'b0;
      stage                   <= cst_pkg::CST_IDLE;
    end
    else
    begin
      lower_mid_threshold_sel <= ctrl_r[`CST_B_COOL_THR +: 2];
      upper_mid_threshold_sel <= ctrl_r[`CST_B_WARM_THR +: 2];
      charge_allowed          <= chg_on & ~susp & ~(|fault_r);
      current_scale           <= (zone_r == cst_pkg::CST_Z_COOL) ? cool_cur : 2'h3;
      voltage_offset          <= (zone_r == cst_pkg::CST_Z_WARM) ? warm_volt : 3'h0;
      // zone does not enter the termination test
      termination             <= chg_on & (&term_sense) & ~reg_any;
      stage                   <= stage_r;
    end
  end

  // ==========================================================
  // checks
  property p_fast_expiry;
    @(posedge pclk) disable iff (!presetn)
    expire[2] |=> fault_r[2] && !event_n;
  endproperty
  a_fast_expiry: assert property (p_fast_expiry) else $error("fast expiry not reported");

  property p_enable_restart;
    @(posedge pclk) disable iff (!presetn)
    $rose(tmr_en[0]) |=> cnt_r[0] == 17'h0_0000;
  endproperty
  a_enable_restart: assert property (p_enable_restart) else $error("timer not restarted");

  property p_disabled_hold;
    @(posedge pclk) disable iff (!presetn)
    !tmr_en[2] && !tmr_rst[2] |=> $stable(cnt_r[2]);
  endproperty
  a_disabled_hold: assert property (p_disabled_hold) else $error("disabled timer moved");

  property p_suspend_hold;
    @(posedge pclk) disable iff (!presetn)
    susp && !(|tmr_rst) |=> $stable(cnt_r[0]) && $stable(cnt_r[1]) && $stable(cnt_r[2])
                            && $stable(reg_half_r);
  endproperty
  a_suspend_hold: assert property (p_suspend_hold) else $error("count moved in suspend");

  property p_half_sticky;
    @(posedge pclk) disable iff (!presetn)
    reg_half_r && reg_any && !susp |=> reg_half_r;
  endproperty
  a_half_sticky: assert property (p_half_sticky) else $error("half rate dropped early");

  property p_dur_reset;
    @(posedge pclk) disable iff (!presetn)
    dur_q_r[2:1] != dur_now[2:1] |=> cnt_r[2] == 17'h0_0000;
  endproperty
  a_dur_reset: assert property (p_dur_reset) else $error("fast timer kept count");

  property p_bypass_zero;
    @(posedge pclk) disable iff (!presetn)
    bypass ##1 bypass |-> zone_r == cst_pkg::CST_Z_NORMAL && !zone_chg;
  endproperty
  a_bypass_zero: assert property (p_bypass_zero) else $error("zone shown in bypass");

  property p_event_width;
    @(posedge pclk) disable iff (!presetn)
    $fell(event_n) |-> !event_n [*8];
  endproperty
  a_event_width: assert property (p_event_width) else $error("event pulse too short");

  property p_zone_flag;
    @(posedge pclk) disable iff (!presetn)
    zone_chg |=> flag_r[`CST_F_ZONE];
  endproperty
  a_zone_flag: assert property (p_zone_flag) else $error("zone flag not set");

  property p_outer_stop;
    @(posedge pclk) disable iff (!presetn)
    zone_r == cst_pkg::CST_Z_HOT |=> !charge_allowed;
  endproperty
  a_outer_stop: assert property (p_outer_stop) else $error("charging outside limits");

endmodule

// ==== tb/cst_host.sv ====
// apb host model standing in for the charger's controlling processor
// assumes pclk from the bench; one transfer outstanding at a time
`timescale 1ns/1ps

module cst_host (
  // clock
  input  wire logic        pclk,
  // apb master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready
);
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = 47'h0;
  end

  // no limit of its own on pready; the bench watchdog cuts a hang
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {psel, penable} <= 2'h0;
  endtask
endmodule

// ==== tb/cst_timer_tb.sv ====
// self-checking bench for the charge safety timer block
// assumes short tick and event parameters so a fast timer expiry fits the run
`timescale 1ns/1ps
`include "cst_regs.svh"

module cst_timer_tb;
  // ==========================================================
  // signals
  localparam int TICK = 4;
  localparam int EVW  = 9;
  logic                     pclk = 1'b0;
  logic                     presetn = 1'b0;
  logic                     psel, penable, pwrite, pready, pslverr;
  logic [11:0]              paddr;
  logic [31:0]              pwdata, prdata, rv;
  logic                     ce_n = 1'b0, recharge_start = 1'b0;
  logic                     vbat_below_short = 1'b0, vbat_below_lowv = 1'b0;
  logic                     charge_fault = 1'b0, supplement_mode = 1'b0;
  logic                     charge_allowed, termination, event_n;
  cst_pkg::cst_reg_loops_t  loops = 3'h0;
  cst_pkg::cst_term_sense_t term_sense = 4'h0;
  logic [3:0]               temp_sense_input = 4'h0;
  logic [1:0]               lo_thr, hi_thr, current_scale;
  logic [2:0]               voltage_offset;
  cst_pkg::cst_stage_t      stage;
  logic [32:0]              exp_q[$], msk_q[$];
  int                       failures = 0, samples_checked = 0, cnt;

  always #25 pclk = ~pclk;

  cst_timer #(.TICK_CYCLES(TICK), .EVENT_CYCLES(EVW)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ce_n(ce_n), .recharge_start(recharge_start), .vbat_below_short(vbat_below_short),
    .vbat_below_lowv(vbat_below_lowv), .charge_fault(charge_fault),
    .supplement_mode(supplement_mode), .loops(loops), .term_sense(term_sense),
    .temp_sense_input(temp_sense_input), .lower_mid_threshold_sel(lo_thr),
    .upper_mid_threshold_sel(hi_thr), .charge_allowed(charge_allowed),
    .current_scale(current_scale), .voltage_offset(voltage_offset),
    .termination(termination), .stage(stage), .event_n(event_n));

  cst_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready));

  // ==========================================================
  // tasks
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e, input logic [32:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    host.xfer(1'b0, a, 32'h0);
  endtask

  task automatic wait_ev(input int lim);
    cnt = 0;
    while (event_n !== 1'b0 && cnt < lim)
    begin
      @(posedge pclk);
      cnt++;
    end
  endtask

  task automatic end_sim;
    if (failures == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // read answers are matched against the oldest note
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite && exp_q.size() > 0)
      chk({pslverr, prdata} & msk_q.pop_front(), exp_q.pop_front());

  // ==========================================================
  // main sequence
  initial
  begin
    void'($urandom(34));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(`CST_OFF_CTRL, {1'b0, `CST_CTRL_RST}, {33{1'b1}});
    rd(12'h00c, 33'h1_0000_0000, {33{1'b1}});
    // trickle enable kept low so the next write restarts that timer
    rv = $urandom & 32'hffff_fffd;
    host.xfer(1'b1, `CST_OFF_CTRL, rv);
    rd(`CST_OFF_CTRL, {1'b0, rv & `CST_CTRL_MASK}, {33{1'b1}});
    chk({29'h0, hi_thr, lo_thr}, {29'h0, rv[19:16]});
    host.xfer(1'b1, `CST_OFF_CTRL, 32'h0000_0cbf);
    repeat (4) @(posedge pclk);
    chk({31'h0, stage}, {31'h0, cst_pkg::CST_FAST});
    {vbat_below_short, vbat_below_lowv} <= 2'h3;
    repeat (4) @(posedge pclk);
    chk({31'h0, stage}, {31'h0, cst_pkg::CST_TRICKLE});
    {vbat_below_short, vbat_below_lowv} <= 2'h0;
    temp_sense_input <= 4'h1;
    host.xfer(1'b1, `CST_OFF_CTRL, 32'h0000_0dbf);
    repeat (5) @(posedge pclk);
    rd(`CST_OFF_STATUS, 33'h1, 33'h71);
    // leave bypass inside the cool zone at 20 percent current
    temp_sense_input <= 4'h2;
    host.xfer(1'b1, `CST_OFF_CTRL, 32'h0000_04bf);
    wait_ev(50);
    chk({32'h0, event_n}, 33'h0);
    cnt = 0;
    while (event_n === 1'b0 && cnt < 50)
    begin
      @(posedge pclk);
      cnt++;
    end
    chk(33'(cnt), 33'(EVW));
    rd(`CST_OFF_STATUS, 33'h10, 33'h70);
    chk({31'h0, current_scale}, 33'h1);
    rd(`CST_OFF_FLAG, 33'h8, 33'h8);
    temp_sense_input <= 4'h1;
    repeat (5) @(posedge pclk);
    rd(`CST_OFF_STATUS, 33'h30, 33'h71);
    // warm zone with an offset code, termination sense all true
    temp_sense_input <= 4'h4;
    term_sense <= 4'hf;
    host.xfer(1'b1, `CST_OFF_CTRL, 32'h0000_34bf);
    repeat (5) @(posedge pclk);
    rd(`CST_OFF_STATUS, 33'h43, 33'h73);
    chk({30'h0, voltage_offset}, 33'h3);
    loops <= 3'h1;
    repeat (2) @(posedge pclk);
    rd(`CST_OFF_STATUS, 33'h400, 33'h402);
    loops <= 3'h0;
    temp_sense_input <= 4'h0;
    repeat (20) @(posedge pclk);
    host.xfer(1'b1, `CST_OFF_FLAG, 32'h0000_000f);
    rd(`CST_OFF_FLAG, 33'h0, 33'hf);
    // shortest fast duration; the field change restarts the count
    host.xfer(1'b1, `CST_OFF_CTRL, 32'h0000_0c3f);
    wait_ev(18000 * TICK + 40);
    chk({32'h0, cnt >= 18000 * TICK - TICK && cnt <= 18000 * TICK + 8}, 33'h1);
    chk({32'h0, event_n}, 33'h0);
    rd(`CST_OFF_STATUS, 33'h4000, 33'h4000);
    rd(`CST_OFF_FLAG, 33'h4, 33'h4);
    end_sim;
  end

  initial
  begin
    #(100000 * 50);
    failures++;
    end_sim;
  end
endmodule
